// >>> ppe_mon_cnt.sv
/*
  Per-queue event counters for one monitor category.
  Assumes a single clock and a queue number in range.
*/
`timescale 1ns/1ps
module ppe_mon_cnt
  import ppe_pkg::*;
(
  // Clock and reset
  input  wire logic                 i_clk,
  input  wire logic                 i_resetn,
  // Count event
  input  wire logic                 i_inc,
  input  wire logic [1:0]           i_queue,
  // Read select
  input  wire logic [1:0]           i_rd_queue,
  output logic      [PPE_CNT_W-1:0] o_count
);
  // Counter array, one word per queue
  logic [PPE_CNT_W-1:0] cnt_r [PPE_NQ];

  // ==================================================
  // Counting
  // Wraps at full scale
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      for (int q = 0; q < PPE_NQ; q++)
        cnt_r[q] <= '0;
    end
    else if (i_inc)
    begin
      cnt_r[i_queue] <= cnt_r[i_queue] + 1'b1;
    end
  end

  // Selected queue for readout
  assign o_count = cnt_r[i_rd_queue];
endmodule // ppe_mon_cnt

// >>> ppe_pkg.sv
/*
  Constants and carrier types for the per-port policing and
  egress register bank. Assumes one 250 MHz clock domain.
*/
package ppe_pkg;
  // ==================================================
  // Register map (byte addresses)
  localparam logic [11:0] PPE_ADDR_PTR   = 12'h804;
  localparam logic [11:0] PPE_ADDR_POL   = 12'h80C;
  localparam logic [11:0] PPE_ADDR_MON   = 12'h810;
  localparam logic [11:0] PPE_ADDR_QIDX  = 12'h900;
  localparam logic [11:0] PPE_ADDR_QIDXB = 12'h903;
  localparam logic [11:0] PPE_ADDR_VID   = 12'h904;
  // ==================================================
  // Field positions
  localparam int PPE_POL_EN     = 0;
  localparam int PPE_POL_BLIND  = 1;
  localparam int PPE_POL_SRP    = 2;
  localparam int PPE_POL_REMAP  = 3;
  localparam int PPE_POL_MARK   = 4;
  localparam int PPE_POL_NIP_LO = 5;
  localparam int PPE_POL_NIP_HI = 6;
  localparam int PPE_POL_PPORT  = 7;
  localparam int PPE_POL_SEL_LO = 8;
  localparam int PPE_POL_SEL_HI = 9;
  localparam int PPE_POL_DALL   = 10;
  localparam int PPE_POL_DONLY  = 11;
  localparam int PPE_POL_W      = 12;
  localparam int PPE_PTR_PI_LO  = 16;
  localparam int PPE_PTR_PI_HI  = 18;
  localparam int PPE_QIDX_HI    = 1;
  localparam int PPE_VID_REPL   = 0;
  // ==================================================
  // Reset values
  localparam logic [11:0] PPE_POL_RST  = 12'h020;
  localparam logic [2:0]  PPE_PI_RST   = 3'h0;
  localparam logic [1:0]  PPE_Q_RST    = 2'h0;
  // ==================================================
  // Colors and monitor selections
  localparam logic [1:0] PPE_SEL_DROP = 2'h0;
  localparam logic [1:0] PPE_GREEN    = 2'h1;
  localparam logic [1:0] PPE_YELLOW   = 2'h2;
  localparam logic [1:0] PPE_RED      = 2'h3;
  localparam int         PPE_CNT_W    = 16;
  localparam int         PPE_NQ       = 4;
  localparam logic [11:0] PPE_VID_ZERO = 12'h000;
  // ==================================================
  // Carriers
  typedef struct packed {
    logic       valid;      // Packet decision request
    logic [1:0] queue;      // Egress queue
    logic       is_ip;      // Frame carries DSCP
    logic       is_srp;     // Stream reservation packet
    logic [1:0] dscp_color; // Color from DSCP
    logic [1:0] remap_color;// Remapped DSCP color
    logic       over_max;   // Above max discard threshold
    logic       prob_drop;  // Multiplier-based drop verdict
  } ppe_pkt_t;
  typedef struct packed {
    logic       valid;      // Decision valid
    logic [1:0] color;      // Resolved color
    logic       drop;       // Discard packet
    logic       mark;       // Write color into DSCP
  } ppe_verdict_t;
  typedef struct packed {
    logic        valid;     // Egress tag present
    logic        dbl_tag;   // Double tagging active
    logic [11:0] outer_vid; // Service-provider tag ID
    logic [11:0] inner_vid; // Customer tag ID
  } ppe_tag_t;
  typedef struct packed {
    logic        police_en;   // Policing and discard on
    logic        color_blind; // Blind mode in force
    logic        per_port;    // Per-port per-queue policing
    logic [2:0]  port_index;  // Indirect port pointer
    logic [1:0]  queue_ptr;   // Indirect queue pointer
    logic [1:0]  tx_queue;    // Queue-indexed access select
  } ppe_cfg_t;
endpackage

// >>> ppe_regs.sv
/*
  Per-port policing, discard and egress control register bank,
  with the per-packet policing verdict, the discard monitor
  counters and the egress VID replacement stage.
  Assumes a plain register port: one-cycle strobes, read data
  in the cycle after the read strobe. Packet inputs are
  synchronous to i_clk.
*/
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ps
module ppe_regs
  import ppe_pkg::*;
(
  // Clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_resetn,
  // Register port
  input  wire logic [11:0]  i_addr,
  input  wire logic [31:0]  i_wdata,
  input  wire logic         i_wr,
  input  wire logic         i_rd,
  output logic      [31:0]  o_rdata,
  // Packet policing
  input  wire ppe_pkt_t     i_pkt,
  output ppe_verdict_t      o_verdict,
  // Egress tag path
  input  wire logic [11:0]  i_def_vid,
  input  wire ppe_tag_t     i_tag,
  output ppe_tag_t          o_tag,
  // Configuration to neighbours
  output ppe_cfg_t          o_cfg
);
  import ppe_pkg::*;
  // Every register here is one flat word per port; the port
  // number is decoded above this bank, so only the low twelve
  // address bits arrive. Strobes are exclusive and one cycle
  // long, so no read-during-write bypass is needed: a read
  // always returns the value left by the last completed write.

  // ==================================================
  // Register storage
  logic [PPE_POL_W-1:0] pol_r;     // Policing control
  logic [PPE_POL_W-1:0] pol_nxt;   // Its next value
  logic [2:0]           pidx_r;    // Port index
  logic [2:0]           pidx_nxt;  // Its next value
  logic [1:0]           qptr_r;    // Queue pointer
  logic [1:0]           qptr_nxt;  // Its next value
  logic [1:0]           txq_r;     // Transmit queue index
  logic [1:0]           txq_nxt;   // Its next value
  logic                 repl_r;    // VID replacement
  logic                 repl_nxt;  // Its next value
  logic [31:0]          rdata_nxt; // Read mux result

  // ==================================================
  // Address decode
  wire hit_ptr;                    // Port pointer word
  wire hit_pol;                    // Policing control word
  wire hit_mon;                    // Monitor count word
  wire hit_qidx;                   // Queue index word
  wire hit_qidxb;                  // Queue index byte alias
  wire hit_vid;                    // VID replacement word
  wire hit_q;                      // Either index form

  assign hit_ptr   = (i_addr == PPE_ADDR_PTR);
  assign hit_pol   = (i_addr == PPE_ADDR_POL);
  assign hit_mon   = (i_addr == PPE_ADDR_MON);
  assign hit_qidx  = (i_addr == PPE_ADDR_QIDX);
  assign hit_qidxb = (i_addr == PPE_ADDR_QIDXB);
  assign hit_vid   = (i_addr == PPE_ADDR_VID);
  // An address that matches none of these reads as zero, and
  // a write to it changes nothing
  // Byte alias carries the low byte in data bits 7:0
  assign hit_q     = hit_qidx | hit_qidxb;
  // No byte enables exist on this port, so a full word write to
  // the byte alias also lands in the index; bits above 1:0 are
  // dropped either way

  // ==================================================
  // Write side
  wire we_ptr;                     // Pointer write
  wire we_pol;                     // Policing write
  wire we_q;                       // Index write
  wire we_vid;                     // VID control write

  assign we_ptr = i_wr & hit_ptr;
  assign we_pol = i_wr & hit_pol;
  assign we_q   = i_wr & hit_q;
  assign we_vid = i_wr & hit_vid;

  // Only implemented bits are taken
  assign pol_nxt  = we_pol ? i_wdata[PPE_POL_W-1:0] : pol_r;
  assign pidx_nxt = we_ptr ? i_wdata[PPE_PTR_PI_HI:PPE_PTR_PI_LO]
                           : pidx_r;
  assign qptr_nxt = we_ptr ? i_wdata[1:0] : qptr_r;
  assign txq_nxt  = we_q ? i_wdata[PPE_QIDX_HI:0] : txq_r;
  assign repl_nxt = we_vid ? i_wdata[PPE_VID_REPL] : repl_r;

  // Register update
  // Reset loads the defaults: everything off, and the non-IP
  // color field at green so that color-aware policing has a
  // sane color before software programs it
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      pol_r  <= PPE_POL_RST;
      pidx_r <= PPE_PI_RST;
      qptr_r <= PPE_Q_RST;
      txq_r  <= PPE_Q_RST;
      repl_r <= 1'b0;
    end
    else
    begin
      pol_r  <= pol_nxt;
      pidx_r <= pidx_nxt;
      qptr_r <= qptr_nxt;
      txq_r  <= txq_nxt;
      repl_r <= repl_nxt;
    end
  end

  // ==================================================
  // Field views
  wire       f_en;                 // Policing enabled
  wire       f_blind;              // Blind bit
  wire       f_srp;                // SRP drop allowed bit
  wire       f_remap;              // Remap bit
  wire       f_mark;               // Mark bit
  wire [1:0] f_nip;                // Non-IP color
  wire       f_pport;              // Per-port policing
  wire [1:0] f_sel;                // Monitor select
  wire       f_dall;               // Drop-all bit
  wire       f_donly;              // Dropped-only counting

  // Named slices of the control word; the verdict logic reads
  // only these, so a moved field stays local to this list
  assign f_en    = pol_r[PPE_POL_EN];
  assign f_blind = pol_r[PPE_POL_BLIND];
  assign f_srp   = pol_r[PPE_POL_SRP];
  assign f_remap = pol_r[PPE_POL_REMAP];
  assign f_mark  = pol_r[PPE_POL_MARK];
  assign f_nip   = pol_r[PPE_POL_NIP_HI:PPE_POL_NIP_LO];
  assign f_pport = pol_r[PPE_POL_PPORT];
  assign f_sel   = pol_r[PPE_POL_SEL_HI:PPE_POL_SEL_LO];
  assign f_dall  = pol_r[PPE_POL_DALL];
  assign f_donly = pol_r[PPE_POL_DONLY];

  // ==================================================
  // Policing verdict
  wire       blind;                // Blind mode in force
  wire       aware;                // Aware mode in force
  wire [1:0] ip_color;             // Color of an IP frame
  wire [1:0] aware_color;          // Color in aware mode
  wire [1:0] color;                // Resolved color
  wire       thr_drop;             // Threshold verdict
  wire       srp_ok;               // SRP may be dropped
  wire       drop;                 // Final discard
  wire       mark;                 // DSCP marking

  // Mode bit only matters while policing is on
  assign blind = f_en & f_blind;
  assign aware = f_en & ~f_blind;

  // DSCP color, optionally remapped
  assign ip_color = f_remap ? i_pkt.remap_color
                            : i_pkt.dscp_color;

  // Non-IP frames take the programmed color; their DSCP inputs
  // carry nothing meaningful and are never looked at
  // Non-IP frames take the programmed color
  assign aware_color = i_pkt.is_ip ? ip_color
                                   : f_nip;

  // Blind and disabled both see every packet green
  assign color = aware ? aware_color : PPE_GREEN;

  // Drop-all overrides the multiplier
  assign thr_drop = f_dall ? i_pkt.over_max
                           : i_pkt.prob_drop;

  // SRP frames are protected unless allowed
  assign srp_ok = ~i_pkt.is_srp | f_srp;

  // No discard at all while disabled
  assign drop = f_en & thr_drop & srp_ok;
  // The SRP guard sits after the threshold choice, so drop-all
  // still spares reserved streams unless bit 2 allows it

  // Marking applies to IP frames only
  assign mark = f_en & f_mark & i_pkt.is_ip;
  // Marking only asks the egress side to write the resolved
  // color back into DSCP; it never changes the verdict color

  ppe_verdict_t verdict_nxt;       // Next verdict
  always_comb
  begin
    verdict_nxt       = '0;
    verdict_nxt.valid = i_pkt.valid;
    if (i_pkt.valid)
    begin
      verdict_nxt.color = color;
      verdict_nxt.drop  = drop;
      verdict_nxt.mark  = mark;
    end
  end

  // Verdict register
  // One-cycle latency; packets may come every cycle, so no
  // verdict is ever held longer than one cycle
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      o_verdict <= '0;
    else
      o_verdict <= verdict_nxt;
  end

  // ==================================================
  // Discard monitor counters
  wire                 cnt_ok;    // Packet qualifies
  wire [3:0]           inc;       // Per-category increment
  wire [PPE_CNT_W-1:0] cnt [4];   // Per-category readout
  wire [1:0]           cat [4];   // Category codes

  // Dropped-only mode counts discards alone
  assign cnt_ok = i_pkt.valid & f_en
                & (~f_donly | drop);

  assign cat[0] = PPE_SEL_DROP;
  assign cat[1] = PPE_GREEN;
  assign cat[2] = PPE_YELLOW;
  assign cat[3] = PPE_RED;

  // Drop category counts every discard
  assign inc[0] = i_pkt.valid & drop;
  // Drop counts ignore the dropped-only bit: they hold discards
  // alone already. Color counts skip color 00, which has no
  // counter of its own
  // Counters are not cleared by a read and wrap at full scale,
  // so software works with differences between two reads

  genvar g;
  generate
    for (g = 1; g < 4; g++)
    begin : g_inc
      assign inc[g] = cnt_ok & (color == cat[g]);
    end
    for (g = 0; g < 4; g++)
    begin : g_cnt
      ppe_mon_cnt u_cnt
      (
        .i_clk      (i_clk),
        .i_resetn   (i_resetn),
        .i_inc      (inc[g]),
        .i_queue    (i_pkt.queue),
        .i_rd_queue (qptr_r),
        .o_count    (cnt[g])
      );
    end
  endgenerate

  // Selected count for the pointed queue
  wire [PPE_CNT_W-1:0] mon_val;
  assign mon_val = cnt[f_sel];

  // ==================================================
  // Read side
  // Monitor readout follows the queue pointer, not the transmit
  // queue index; the two select different things
  always_comb
  begin
    rdata_nxt = '0;
    if (hit_pol)
      rdata_nxt[PPE_POL_W-1:0] = pol_r;
    else if (hit_ptr)
    begin
      rdata_nxt[PPE_PTR_PI_HI:PPE_PTR_PI_LO] = pidx_r;
      rdata_nxt[1:0] = qptr_r;
    end
    else if (hit_mon)
      rdata_nxt[PPE_CNT_W-1:0] = mon_val;
    else if (hit_q)
      rdata_nxt[PPE_QIDX_HI:0] = txq_r;
    else if (hit_vid)
      rdata_nxt[PPE_VID_REPL] = repl_r;
  end

  // Read data valid the cycle after the strobe
  // Zero outside the answer cycle keeps an OR of banks clean
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      o_rdata <= '0;
    else if (i_rd)
      o_rdata <= rdata_nxt;
    else
      o_rdata <= '0;
  end

  // ==================================================
  // Egress VID replacement
  ppe_vid_repl u_vid
  (
    .i_clk     (i_clk),
    .i_resetn  (i_resetn),
    .i_repl_en (repl_r),
    .i_def_vid (i_def_vid),
    .i_tag     (i_tag),
    .o_tag     (o_tag)
  );

  // ==================================================
  // Configuration export
  // Neighbours use tx_queue for indexed accesses
  // Port index is only exported: this bank counts its own port,
  // and the per-port policing tables live with the neighbours
  always_comb
  begin
    o_cfg             = '0;
    o_cfg.police_en   = f_en;
    o_cfg.color_blind = blind;
    o_cfg.per_port    = f_pport;
    o_cfg.port_index  = pidx_r;
    o_cfg.queue_ptr   = qptr_r;
    o_cfg.tx_queue    = txq_r;
  end
endmodule // ppe_regs

// >>> ppe_regs_props.sv
/*
  Concurrent checks for ppe_regs, built only on its ports.
  Assumes one clock domain and a reset held low for at least one edge.
*/
`timescale 1ns/1ps
module ppe_regs_props
  import ppe_pkg::*;
(
  // Clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_resetn,
  // Register port
  input  wire logic [11:0]  i_addr,
  input  wire logic [31:0]  i_wdata,
  input  wire logic         i_wr,
  input  wire logic         i_rd,
  input  wire logic [31:0]  o_rdata,
  // Packet and tag paths
  input  wire ppe_pkt_t     i_pkt,
  input  wire ppe_verdict_t o_verdict,
  input  wire logic [11:0]  i_def_vid,
  input  wire ppe_tag_t     i_tag,
  input  wire ppe_tag_t     o_tag,
  input  wire ppe_cfg_t     o_cfg
);
  // ==================================================
  // Shadows of the written registers
  logic [11:0] pol_r;  // Policing control
  logic        vid_r;  // Replace enable
  logic [1:0]  q_r;    // Queue index
  logic [4:0]  ptr_r;  // Port index and queue pointer
  wire  [1:0]  aw_col; // Expected color in aware mode
  assign aw_col = !i_pkt.is_ip ? pol_r[6:5] : pol_r[3] ? i_pkt.remap_color : i_pkt.dscp_color;
  // Follow every accepted write
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      pol_r <= PPE_POL_RST;
      vid_r <= 1'b0;
      q_r   <= 2'h0;
      ptr_r <= 5'h00;
    end
    else if (i_wr)
    begin
      if (i_addr == PPE_ADDR_POL)
        pol_r <= i_wdata[11:0];
      if (i_addr == PPE_ADDR_VID)
        vid_r <= i_wdata[0];
      if (i_addr == PPE_ADDR_QIDX || i_addr == PPE_ADDR_QIDXB)
        q_r <= i_wdata[1:0];
      if (i_addr == PPE_ADDR_PTR)
        ptr_r <= {i_wdata[18:16], i_wdata[1:0]};
    end
  end
  // ==================================================
  // Properties
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  sequence s_pkt;
    i_pkt.valid;
  endsequence
  sequence s_tag(d);
    i_tag.valid && vid_r && i_tag.dbl_tag == d;
  endsequence
  chk_cfg_police: assert property (
    o_cfg.police_en == pol_r[0] && o_cfg.per_port == pol_r[7]
    && o_cfg.color_blind == (pol_r[0] && pol_r[1])) else $error("cfg police mismatch");
  chk_cfg_index: assert property (
    o_cfg.tx_queue == q_r && {o_cfg.port_index, o_cfg.queue_ptr} == ptr_r)
    else $error("cfg index mismatch");
  chk_read_pol: assert property (
    i_rd && i_addr == PPE_ADDR_POL |=> o_rdata == {20'h0, $past(pol_r)})
    else $error("police read mismatch");
  chk_off_green: assert property (
    s_pkt ##0 !pol_r[0] |=> o_verdict.color == PPE_GREEN && !o_verdict.drop && !o_verdict.mark)
    else $error("disabled verdict wrong");
  chk_blind_green: assert property (
    s_pkt ##0 pol_r[1:0] == 2'h3 |=> o_verdict.color == PPE_GREEN) else $error("blind color");
  chk_srp_kept: assert property (
    s_pkt ##0 (i_pkt.is_srp && !pol_r[2]) |=> !o_verdict.drop) else $error("srp dropped");
  chk_aware_color: assert property (
    s_pkt ##0 pol_r[1:0] == 2'h1 |=> o_verdict.color == $past(aw_col)) else $error("aware color");
  chk_mark_gate: assert property (
    s_pkt |=> o_verdict.valid && o_verdict.mark == $past(pol_r[0] && pol_r[4] && i_pkt.is_ip))
    else $error("mark wrong");
  chk_drop_all: assert property (
    s_pkt ##0 (pol_r[0] && pol_r[10] && !i_pkt.is_srp)
    |=> o_verdict.drop == $past(i_pkt.over_max))
    else $error("drop all wrong");
  chk_vid_inner: assert property (
    s_tag(1'b0) ##0 i_tag.inner_vid != PPE_VID_ZERO |=> o_tag.inner_vid == $past(i_def_vid))
    else $error("inner vid kept");
  chk_vid_outer: assert property (
    s_tag(1'b1) ##0 i_tag.outer_vid != PPE_VID_ZERO |=> o_tag.outer_vid == $past(i_def_vid)
    && o_tag.inner_vid == $past(i_tag.inner_vid)) else $error("outer vid wrong");
endmodule // ppe_regs_props
bind ppe_regs ppe_regs_props ppe_regs_props_i (.i_clk(i_clk), .i_resetn(i_resetn),
  .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
  .i_pkt(i_pkt), .o_verdict(o_verdict), .i_def_vid(i_def_vid), .i_tag(i_tag),
  .o_tag(o_tag), .o_cfg(o_cfg));

// >>> ppe_vid_repl.sv
/*
  Egress VLAN ID replacement stage.
  Assumes the port default VID is stable while packets flow.
*/
`timescale 1ns/1ps
module ppe_vid_repl
  import ppe_pkg::*;
(
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_resetn,
  // Control
  input  wire logic        i_repl_en,
  input  wire logic [11:0] i_def_vid,
  // Tag in and out
  input  wire ppe_tag_t    i_tag,
  output ppe_tag_t         o_tag
);
  ppe_tag_t tag_nxt;           // Rewritten tag
  wire      tgt_nz;            // Targeted ID non-zero
  wire      repl;              // Replacement applies

  // Outer tag is the target when double tagged
  assign tgt_nz = i_tag.dbl_tag ? (i_tag.outer_vid != PPE_VID_ZERO)
                                : (i_tag.inner_vid != PPE_VID_ZERO);
  assign repl   = i_repl_en & tgt_nz;

  always_comb
  begin
    tag_nxt = i_tag;
    if (repl && i_tag.dbl_tag)
      tag_nxt.outer_vid = i_def_vid;
    else if (repl)
      tag_nxt.inner_vid = i_def_vid;
  end

  // ==================================================
  // Output register
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      o_tag <= '0;
    else
      o_tag <= tag_nxt;
  end
endmodule // ppe_vid_repl

// >>> test_ppe_regs.sv
/*
  Self-checking bench for ppe_regs: registers, verdicts, counters, tags.
  Assumes the checker is bound separately; the bench drives every port.
*/
`timescale 1ns/1ps
module test_ppe_regs;
  import ppe_pkg::*;
  // ==================================================
  // Signals and model state
  logic         i_clk     = 1'b0;
  logic         i_resetn  = 1'b0;
  logic [11:0]  i_addr    = 12'h000;
  logic [31:0]  i_wdata   = 32'h0;
  logic         i_wr      = 1'b0;
  logic         i_rd      = 1'b0;
  logic [31:0]  o_rdata;
  ppe_pkt_t     i_pkt     = '0;
  ppe_verdict_t o_verdict;
  logic [11:0]  i_def_vid = 12'h000;
  ppe_tag_t     i_tag     = '0;
  ppe_tag_t     o_tag;
  ppe_cfg_t     o_cfg;
  int           errors    = 0;
  int           n_tests   = 0;
  integer       seed      = 32'hC9F8;
  logic [31:0]  rnd;             // Scratch random word
  logic [31:0]  rq[$];           // Expected read data
  ppe_verdict_t vq[$];           // Expected verdicts
  ppe_tag_t     tq[$];           // Expected tags
  logic         rd_d      = 1'b0; // Read data due now
  logic [11:0]  pol;             // Policing control shadow
  logic         vrep;            // Replace enable shadow
  logic [15:0]  cnt[4][4];       // Counters by select and queue
  always #2 i_clk = ~i_clk;
  ppe_regs ppe_regs_i (.i_clk(i_clk), .i_resetn(i_resetn), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_pkt(i_pkt),
    .o_verdict(o_verdict), .i_def_vid(i_def_vid), .i_tag(i_tag), .o_tag(o_tag),
    .o_cfg(o_cfg));
  // ==================================================
  // Bus cycles and compare
  task automatic cyc(input logic w, input logic r, input logic [11:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_wr    <= w;
    i_rd    <= r;
    i_addr  <= a;
    i_wdata <= d;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    cyc(1'b0, 1'b1, a, 32'h0);
    rq.push_back(e);
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      errors++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  // One random packet and tag, expectations noted first
  task automatic pkt_step();
    ppe_pkt_t     p;
    ppe_verdict_t v;
    ppe_tag_t     t;
    ppe_tag_t     e;
    logic [31:0]  r;
    r = $random(seed);
    p = ppe_pkt_t'(r[10:0]);
    p.valid = 1'b1;
    v.valid = 1'b1;
    v.color = (!pol[0] || pol[1]) ? PPE_GREEN : !p.is_ip ? pol[6:5]
              : pol[3] ? p.remap_color : p.dscp_color;
    v.drop = pol[0] && (pol[10] ? p.over_max : p.prob_drop)
             && (!p.is_srp || pol[2]);
    v.mark = pol[0] && pol[4] && p.is_ip;
    vq.push_back(v);
    if (v.drop)
      cnt[0][p.queue]++;
    if (pol[0] && v.color != 2'h0 && (!pol[11] || v.drop))
      cnt[v.color][p.queue]++;
    r = $random(seed);
    t = ppe_tag_t'(r[25:0]);
    if (r[26])
      t.inner_vid = PPE_VID_ZERO;
    if (r[27])
      t.outer_vid = PPE_VID_ZERO;
    e = t;
    if (vrep && t.dbl_tag && t.outer_vid != PPE_VID_ZERO)
      e.outer_vid = i_def_vid;
    if (vrep && !t.dbl_tag && t.inner_vid != PPE_VID_ZERO)
      e.inner_vid = i_def_vid;
    if (t.valid)
      tq.push_back(e);
    @(posedge i_clk);
    i_wr  <= 1'b0;
    i_pkt <= p;
    i_tag <= t;
  endtask
  // ==================================================
  // Output watcher
  always @(posedge i_clk)
    rd_d <= i_rd;
  always @(negedge i_clk)
  begin
    if (rd_d)
      chk("rdata", rq.pop_front(), o_rdata);
    if (o_verdict.valid)
      chk("verdict", 32'(vq.pop_front()), 32'(o_verdict));
    if (o_tag.valid)
      chk("tag", 32'(tq.pop_front()), 32'(o_tag));
  end
  // ==================================================
  // Verdict and end of run
  task automatic final_report();
    if (errors == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    repeat (5000) @(posedge i_clk);
    errors++;
    final_report();
  end
  // ==================================================
  // Main sequence
  initial
  begin
    for (int s = 0; s < 4; s++)
      for (int q = 0; q < 4; q++)
        cnt[s][q] = 16'h0000;
    repeat (16) @(posedge i_clk);
    i_resetn <= 1'b1;
    // Reset values
    rd(PPE_ADDR_POL, 32'h0000_0020);
    rd(PPE_ADDR_QIDX, 32'h0);
    rd(PPE_ADDR_VID, 32'h0);
    rd(PPE_ADDR_PTR, 32'h0);
    // Reserved bits, byte alias, unmapped and read-only places
    cyc(1'b1, 1'b0, PPE_ADDR_POL, 32'hFFFF_FFFF);
    rd(PPE_ADDR_POL, 32'h0000_0FFF);
    cyc(1'b1, 1'b0, PPE_ADDR_PTR, 32'hFFFF_FFFF);
    rd(PPE_ADDR_PTR, 32'h0007_0003);
    cyc(1'b1, 1'b0, PPE_ADDR_QIDX, 32'hFFFF_FFFF);
    rd(PPE_ADDR_QIDX, 32'h0000_0003);
    cyc(1'b1, 1'b0, PPE_ADDR_QIDXB, 32'h0000_0002);
    rd(PPE_ADDR_QIDXB, 32'h0000_0002);
    rd(PPE_ADDR_QIDX, 32'h0000_0002);
    cyc(1'b1, 1'b0, PPE_ADDR_VID, 32'hFFFF_FFFF);
    rd(PPE_ADDR_VID, 32'h0000_0001);
    cyc(1'b1, 1'b0, 12'h808, 32'hFFFF_FFFF);
    rd(12'h808, 32'h0);
    cyc(1'b1, 1'b0, PPE_ADDR_MON, 32'hFFFF_FFFF);
    rd(PPE_ADDR_MON, 32'h0);
    // Random traffic under eight configurations
    for (int k = 0; k < 8; k++)
    begin
      rnd = $random(seed);
      pol = rnd[11:0];
      if (!k[0])
        pol[1:0] = 2'h1;
      // Force blind, off, drop-all with dropped-only, and SRP kept
      if (k == 1)
        pol[1:0] = 2'h3;
      if (k == 3)
        pol[0] = 1'b0;
      if (k == 2)
        pol[11:10] = 2'h3;
      if (k == 4)
        pol[2] = 1'b0;
      vrep = k[1];
      cyc(1'b1, 1'b0, PPE_ADDR_POL, {20'h0, pol});
      // Last packet and tag of the previous setting taken; go idle
      i_pkt <= '0;
      i_tag <= '0;
      i_def_vid <= rnd[27:16];
      cyc(1'b1, 1'b0, PPE_ADDR_VID, {31'h0, vrep});
      repeat (40) pkt_step();
    end
    cyc(1'b0, 1'b0, 12'h000, 32'h0);
    i_pkt <= '0;
    i_tag <= '0;
    // Monitor counters for every select and queue
    for (int s = 0; s < 4; s++)
      for (int q = 0; q < 4; q++)
      begin
        cyc(1'b1, 1'b0, PPE_ADDR_PTR, {13'h0, 3'h5, 14'h0, 2'(q)});
        cyc(1'b1, 1'b0, PPE_ADDR_POL, {20'h0, pol[11:10], 2'(s), pol[7:0]});
        rd(PPE_ADDR_MON, {16'h0, cnt[s][q]});
      end
    cyc(1'b0, 1'b0, 12'h000, 32'h0);
    repeat (3) @(posedge i_clk);
    chk("queues", 32'h0, 32'(rq.size() + vq.size() + tq.size()));
    final_report();
  end
endmodule // test_ppe_regs
